// *** fwsr_pkg.sv ***
/*
 * shared constants for the flash write-status host controller.
 * assumes a 40 MHz system clock and a 16-bit asynchronous NOR flash data bus.
 */
package fwsr_pkg;
    // ***************************************************************
    // timing
    // ***************************************************************
    localparam int CLK_PERIOD_PS = 25000;
    localparam int RD_PULSE_NS = 100;
    localparam int RD_PULSE_CYC = (RD_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WR_PULSE_NS = 75;
    localparam int WR_PULSE_CYC = (WR_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int GAP_NS = 50;
    localparam int GAP_CYC = (GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // ***************************************************************
    // register map (word offsets are byte addresses)
    // ***************************************************************
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h4;
    localparam logic [3:0] REG_WDATA = 4'h8;
    localparam logic [3:0] REG_STAT = 4'hc;
    // ctrl fields
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_WR_BIT = 1;
    localparam int CTRL_POLL_BIT = 2;
    localparam int CTRL_TGL_BIT = 3;
    // status word fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_DONE_BIT = 1;
    localparam int ST_FAIL_BIT = 2;
    localparam int ST_RYBY_BIT = 3;
    // flash data bit positions
    localparam int POLL_POS = 7;
    localparam int TGL1_POS = 6;
    localparam int TMO_POS = 5;
    localparam int TGL2_POS = 2;
    localparam logic [15:0] RESET_CMD = 16'h00f0;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage

// *** fwsr_sync.sv ***
/*
 * three-flop synchroniser with agreement qualify for pin inputs.
 * assumes the input is asynchronous to i_clock.
 */
`timescale 1ns/100ps
module fwsr_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_arst_n,
    // data
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    // a zero-width chain has nothing to carry
    if (W < 1) begin : g_bad_width
        $error("fwsr_sync width must be at least one");
    end
    // chain; the accepted value changes only when stages two and three agree
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            o_q <= '0;
        end else begin
            s1_q <= i_d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    o_q[i] <= s3_q[i];
                end
            end
        end
    end
endmodule

// *** fwsr_host.sv ***
/*
 * host-side controller: issues single flash writes and reads, and runs the
 * polling or toggle status procedure after a program/erase command.
 * assumes software issues the command sequence via single writes, then starts a
 * poll at the program address or a sector selected for erasure.
 */
// Chosen here: the Wishbone register port and the placing of the registers.
`timescale 1ns/100ps
// Contract
// - host reads program status at the program address.
// - host reads erase status inside a selected sector.
// - poll bit may flip alone; host takes full data on following reads.
// - host reads twice back to back; unchanged bit means complete.
// - still toggling with timeout flag high: retest, then fail and reset.
// - resuming monitoring restarts toggle detection from the start.
// - polling rechecks poll bit after seeing timeout flag high.
module fwsr_host (
    // clock and reset
    input wire logic I_CLOCK,
    input wire logic I_ARST_N,
    // wishbone slave
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [3:0] I_WB_ADR,
    input wire logic [3:0] I_WB_SEL,
    input wire logic [31:0] I_WB_DAT,
    output logic [31:0] O_WB_DAT,
    output logic O_WB_ACK,
    // flash pins
    output logic [20:0] O_FL_ADDR,
    output logic [15:0] O_FL_DQ_OUT,
    output logic O_FL_DQ_OE,
    input wire logic [15:0] I_FL_DQ_IN,
    output logic O_FL_CE_N,
    output logic O_FL_OE_N,
    output logic O_FL_WE_N,
    input wire logic I_FL_READY_BUSY_N
);
    import fwsr_pkg::*;
    typedef enum {S_IDLE, S_WSTB, S_RSTB, S_GAP, S_EVAL, S_RST} fwsr_state_t;
    // ***************************************************************
    // registers and synchronised pins
    // ***************************************************************
    fwsr_state_t st_q;
    logic [3:0] ctrl_q;
    logic [20:0] addr_q;
    logic [15:0] wdata_q;
    logic [15:0] rdata_q;
    logic busy_q, done_q, fail_q;
    logic [7:0] cnt_q;
    logic [1:0] nrd_q;
    logic tmo_seen_q;
    logic prev_q;
    logic rst_after_q;
    logic [15:0] dq_s;
    logic ryby_s;
    fwsr_sync #(.W(17)) u_sync (
        .i_clock(I_CLOCK),
        .i_arst_n(I_ARST_N),
        .i_d({I_FL_READY_BUSY_N, I_FL_DQ_IN}),
        .o_q({ryby_s, dq_s})
    );
    // bit under test: poll bit for polling mode, else toggle bit one
    function automatic logic test_bit(input logic [15:0] d, input logic poll);
        test_bit = poll ? d[POLL_POS] : d[TGL1_POS];
    endfunction
    wire wb_req = I_WB_CYC && I_WB_STB && !O_WB_ACK;
    wire go_wr = wb_req && I_WB_WE && I_WB_ADR == REG_CTRL && I_WB_SEL[0] && I_WB_DAT[CTRL_GO_BIT] && !busy_q;
    // ***************************************************************
    // wishbone slave, ack one cycle after request
    // ***************************************************************
    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_WB_ACK <= 1'b0;
            O_WB_DAT <= RST_WORD;
            ctrl_q <= 4'h0;
            addr_q <= 21'h0;
            wdata_q <= 16'h0;
        end else begin
            O_WB_ACK <= wb_req;
            if (wb_req && I_WB_WE) begin
                case (I_WB_ADR)
                    REG_CTRL: if (I_WB_SEL[0] && !busy_q) ctrl_q <= I_WB_DAT[3:0];
                    REG_ADDR: if (I_WB_SEL == 4'hf) addr_q <= I_WB_DAT[20:0];
                    REG_WDATA: if (I_WB_SEL[1:0] == 2'h3) wdata_q <= I_WB_DAT[15:0];
                    default: ;
                endcase
            end
            case (I_WB_ADR)
                REG_CTRL: O_WB_DAT <= {28'h0, ctrl_q};
                REG_ADDR: O_WB_DAT <= {11'h0, addr_q};
                REG_WDATA: O_WB_DAT <= {16'h0, wdata_q};
                REG_STAT: O_WB_DAT <= {rdata_q, 12'h0, ryby_s, fail_q, done_q, busy_q};
                default: O_WB_DAT <= RST_WORD;
            endcase
        end
    end
    // ***************************************************************
    // bus cycle sequencer and status procedure
    // ***************************************************************
    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            st_q <= S_IDLE;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            fail_q <= 1'b0;
            cnt_q <= 8'h0;
            nrd_q <= 2'h0;
            tmo_seen_q <= 1'b0;
            prev_q <= 1'b0;
            rst_after_q <= 1'b0;
            rdata_q <= 16'h0;
            O_FL_ADDR <= 21'h0;
            O_FL_DQ_OUT <= 16'h0;
            O_FL_DQ_OE <= 1'b0;
            O_FL_CE_N <= 1'b1;
            O_FL_OE_N <= 1'b1;
            O_FL_WE_N <= 1'b1;
        end else begin
            case (st_q)
                S_IDLE: begin
                    if (go_wr) begin
                        busy_q <= 1'b1;
                        done_q <= 1'b0;
                        fail_q <= 1'b0;
                        nrd_q <= 2'h0;
                        tmo_seen_q <= 1'b0;
                        rst_after_q <= 1'b0;
                        O_FL_ADDR <= addr_q;
                        O_FL_CE_N <= 1'b0;
                        cnt_q <= 8'h0;
                        if (I_WB_DAT[CTRL_WR_BIT]) begin
                            O_FL_DQ_OUT <= wdata_q;
                            O_FL_DQ_OE <= 1'b1;
                            O_FL_WE_N <= 1'b0;
                            st_q <= S_WSTB;
                        end else begin
                            O_FL_OE_N <= 1'b0;
                            st_q <= S_RSTB;
                        end
                    end
                end
                S_WSTB: begin
                    cnt_q <= cnt_q + 8'h1;
                    if (cnt_q == 8'(WR_PULSE_CYC - 1)) begin
                        O_FL_WE_N <= 1'b1;
                        O_FL_CE_N <= 1'b1;
                        cnt_q <= 8'h0;
                        st_q <= S_GAP;
                    end
                end
                S_RSTB: begin
                    cnt_q <= cnt_q + 8'h1;
                    // sync latency is 4 cycles (three flops and the qualified output); pulse is long enough to cover it
                    if (cnt_q == 8'(RD_PULSE_CYC + 3)) begin
                        rdata_q <= dq_s;
                        O_FL_OE_N <= 1'b1;
                        O_FL_CE_N <= 1'b1;
                        cnt_q <= 8'h0;
                        st_q <= S_EVAL;
                    end
                end
                S_EVAL: begin
                    st_q <= S_GAP;
                    if (!(ctrl_q[CTRL_POLL_BIT] || ctrl_q[CTRL_TGL_BIT]) || rst_after_q) begin
                        done_q <= 1'b1;
                    end else if (ctrl_q[CTRL_POLL_BIT]) begin
                        // done only on match seen in a read; final word read afterward
                        if (rdata_q[POLL_POS] == wdata_q[POLL_POS]) begin
                            if (nrd_q == 2'h2) done_q <= 1'b1;
                            else nrd_q <= 2'h2;
                        end else if (tmo_seen_q) begin
                            fail_q <= 1'b1;
                        end else if (rdata_q[TMO_POS]) begin
                            tmo_seen_q <= 1'b1;
                        end
                    end else begin
                        prev_q <= test_bit(rdata_q, 1'b0);
                        if (nrd_q == 2'h0) begin
                            nrd_q <= 2'h1;
                        end else if (test_bit(rdata_q, 1'b0) == prev_q) begin
                            if (nrd_q == 2'h2) done_q <= 1'b1;
                            else nrd_q <= 2'h2;
                        end else if (tmo_seen_q) begin
                            fail_q <= 1'b1;
                        end else if (rdata_q[TMO_POS]) begin
                            tmo_seen_q <= 1'b1;
                        end
                    end
                end
                S_GAP: begin
                    O_FL_DQ_OE <= 1'b0;
                    cnt_q <= cnt_q + 8'h1;
                    if (cnt_q == 8'(GAP_CYC - 1)) begin
                        cnt_q <= 8'h0;
                        if (fail_q && !rst_after_q) begin
                            st_q <= S_RST;
                        end else if (done_q || !(ctrl_q[CTRL_POLL_BIT] || ctrl_q[CTRL_TGL_BIT])
                                     || ctrl_q[CTRL_WR_BIT] || rst_after_q) begin
                            busy_q <= 1'b0;
                            done_q <= 1'b1;
                            st_q <= S_IDLE;
                        end else begin
                            O_FL_CE_N <= 1'b0;
                            O_FL_OE_N <= 1'b0;
                            st_q <= S_RSTB;
                        end
                    end
                end
                S_RST: begin
                    // failed operation: write reset command, then finish
                    O_FL_DQ_OUT <= RESET_CMD;
                    O_FL_DQ_OE <= 1'b1;
                    O_FL_CE_N <= 1'b0;
                    O_FL_WE_N <= 1'b0;
                    rst_after_q <= 1'b1;
                    st_q <= S_WSTB;
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end
    // ***************************************************************
    // checks
    // ***************************************************************
    a_ack_one_cycle: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
        O_WB_ACK |=> !O_WB_ACK) else $error("ack longer than one cycle");
    a_no_drive_read: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
        !O_FL_OE_N |-> !O_FL_DQ_OE) else $error("bus contention");
    a_we_pulse_len: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
        $fell(O_FL_WE_N) |-> !O_FL_WE_N [*3] ##1 O_FL_WE_N) else $error("write pulse length");
    a_fail_resets: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
        $rose(fail_q) |-> ##[1:8] !O_FL_WE_N) else $error("no reset after failure");
    // one read strobe covers the pulse plus the synchroniser latency
    sequence s_read_held;
        !O_FL_OE_N [*8] ##1 O_FL_OE_N;
    endsequence
    // reads stay apart so each one counts as its own toggle event
    sequence s_gap_held;
        O_FL_OE_N [*3];
    endsequence
    a_read_pulse_len: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
        $fell(O_FL_OE_N) |-> s_read_held) else $error("read pulse length");
    a_read_gap: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
        $rose(O_FL_OE_N) |-> s_gap_held) else $error("reads run together");
    a_addr_held: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
        busy_q && $past(busy_q) |-> $stable(O_FL_ADDR)) else $error("address moved during operation");
endmodule

// *** fwsr_flash_model.sv ***
/*
 * behavioural flash device seen by the host controller: status words while busy,
 * array data otherwise, ready/busy driven high when idle or suspended.
 * assumes the bench arms it before the write that starts an operation.
 */
`timescale 1ns/100ps
module fwsr_flash_model
    import fwsr_pkg::*;
(
    // host pins
    input wire logic [20:0] i_addr,
    input wire logic [15:0] i_dq,
    input wire logic i_ce_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    // scenario control
    input wire logic i_arm,
    input wire logic i_erase,
    input wire logic i_stuck,
    input wire logic i_prot,
    input wire logic i_susp,
    input wire logic [7:0] i_len,
    // outputs
    output logic [15:0] o_dq,
    output logic o_ready_busy_n,
    output logic o_reset_seen
);
    // ***************************************************************
    // state
    // ***************************************************************
    logic busy = 1'b0;
    logic tgl1 = 1'b0;
    logic tgl2 = 1'b0;
    logic [15:0] pd = 16'h0000;
    logic [15:0] arr = 16'hffff;
    logic [20:0] pa = 21'h000000;
    logic [7:0] left = 8'h00;
    logic at_op;
    logic poll_st;
    logic [15:0] cur;
    initial o_reset_seen = 1'b0;
    // operation starts only when the final write strobe rises
    always @(posedge i_we_n) begin
        if (i_dq === RESET_CMD) begin
            busy = 1'b0;
            o_reset_seen = 1'b1;
        end else if (i_arm === 1'b1) begin
            pa = i_addr;
            pd = i_dq;
            busy = 1'b1;
            left = i_len;
        end
    end
    // one toggle event per finished read; a stuck op never completes
    always @(posedge i_oe_n) begin
        if (busy) begin
            // a suspended erase freezes toggle bit one and makes no progress
            if (!i_susp) tgl1 = ~tgl1;
            if (i_erase) tgl2 = ~tgl2;
            if (!i_stuck && !i_susp) begin
                left = left - 8'h01;
                if (left == 8'h00) begin
                    busy = 1'b0;
                    // a protected target keeps its old contents
                    if (!i_prot) arr = i_erase ? 16'hffff : pd;
                end
            end
        end
    end
    // poll bit is only trustworthy at the operation's address or sector
    assign at_op = i_erase ? (i_addr[20:12] == pa[20:12]) : (i_addr == pa);
    assign poll_st = (i_erase ? i_susp : ~pd[7]) ^ !at_op;
    // status word while busy; array contents (erased reads all ones) when done
    assign cur = busy ? {pd[15:8], poll_st, tgl1, i_stuck, 2'b00, tgl2, 2'b00}
                      : arr;
    // released bus shows the inverse so a stale value never passes as data
    assign o_dq = (!i_oe_n && !i_ce_n) ? cur : ~cur;
    assign o_ready_busy_n = !busy || i_susp;
endmodule

// *** fwsr_host_tb.sv ***
/*
 * self-checking bench for the host controller: wishbone tasks drive program,
 * erase and stuck operations against the flash model and check the status word.
 * assumes the register map and status layout of the package.
 */
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin errors++; \
    $display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end
module fwsr_host_tb;
    import fwsr_pkg::*;
    // ***************************************************************
    // signals and instances
    // ***************************************************************
    logic clk = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0] adr = 4'h0, sel = 4'h0;
    logic [31:0] dat = 32'h0, rdat, st;
    logic ack, ce_n, oe_n, we_n, dq_oe, ryby_n, rst_seen;
    logic arm = 1'b0, erase = 1'b0, stuck = 1'b0, prot = 1'b0, susp = 1'b0;
    logic [7:0] len = 8'h03;
    logic [20:0] fl_addr;
    logic [15:0] dq_out, dq_in;
    int errors = 0, check_count = 0;
    always #12.5 clk = ~clk;
    fwsr_host u_fwsr_host (.I_CLOCK(clk), .I_ARST_N(arst_n), .I_WB_CYC(cyc), .I_WB_STB(stb),
        .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(dat), .O_WB_DAT(rdat),
        .O_WB_ACK(ack), .O_FL_ADDR(fl_addr), .O_FL_DQ_OUT(dq_out), .O_FL_DQ_OE(dq_oe),
        .I_FL_DQ_IN(dq_in), .O_FL_CE_N(ce_n), .O_FL_OE_N(oe_n), .O_FL_WE_N(we_n),
        .I_FL_READY_BUSY_N(ryby_n));
    // the model only sees written data while the controller actually drives the bus
    fwsr_flash_model u_fwsr_flash_model (.i_addr(fl_addr), .i_dq(dq_oe ? dq_out : ~dq_out), .i_ce_n(ce_n),
        .i_oe_n(oe_n), .i_we_n(we_n), .i_arm(arm), .i_erase(erase), .i_stuck(stuck),
        .i_prot(prot), .i_susp(susp), .i_len(len), .o_dq(dq_in), .o_ready_busy_n(ryby_n),
        .o_reset_seen(rst_seen));
    // ***************************************************************
    // bus tasks
    // ***************************************************************
    // one classic cycle; held until ack is sampled, released after it
    task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; dat <= d;
        // only the watchdog ends a wait for ack
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask
    // poll the status register until the controller reports idle
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            wb(1'b0, REG_STAT, 4'hf, 32'h0, st);
            n++;
        end while (st[ST_BUSY_BIT] !== 1'b0 && n < 300);
        if (st[ST_BUSY_BIT] !== 1'b0) begin
            errors++;
            close_out();
        end
    endtask
    // write one word, then run the chosen status procedure at the same address
    task automatic run_op(input logic [20:0] a, input logic [15:0] d, input int mode_bit);
        logic [31:0] q;
        wb(1'b1, REG_ADDR, 4'hf, {11'h000, a}, q);
        wb(1'b1, REG_WDATA, 4'h3, {16'h0000, d}, q);
        arm <= 1'b1;
        wb(1'b1, REG_CTRL, 4'h1, 32'h3, q);
        wait_idle();
        arm <= 1'b0;
        wb(1'b1, REG_CTRL, 4'h1, 32'h1 | (32'h1 << mode_bit), q);
        wait_idle();
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ***************************************************************
    // tests
    // ***************************************************************
    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        // let the ready pin pass the synchroniser, which starts out low
        repeat (8) @(posedge clk);
        wait_idle();
        `CHK("idle stat", 4'h8, st[3:0])
        wb(1'b0, 4'h2, 4'hf, 32'h0, st);
        `CHK("unmapped", 32'h0, st)
        // program with bit7 set: poll reads inverse until done
        run_op(21'h00_0123, 16'h5a80, CTRL_POLL_BIT);
        `CHK("prog poll flags", 4'ha, st[3:0])
        `CHK("prog poll data", 16'h5a80, st[31:16])
        // erase watched by toggle bit one
        erase <= 1'b1; len <= 8'h05;
        run_op(21'h01_0000, 16'h0030, CTRL_TGL_BIT);
        `CHK("erase tgl flags", 4'ha, st[3:0])
        `CHK("erase tgl data", 16'hffff, st[31:16])
        // program, toggle procedure, bit7 clear
        erase <= 1'b0; len <= 8'h02;
        run_op(21'h00_0200, 16'h1234, CTRL_TGL_BIT);
        `CHK("prog tgl data", 16'h1234, st[31:16])
        // stuck program: timeout flag, retest, fail, reset command
        stuck <= 1'b1;
        run_op(21'h00_0300, 16'h0011, CTRL_POLL_BIT);
        `CHK("stuck fail", 1'b1, st[ST_FAIL_BIT])
        `CHK("stuck reset", 1'b1, rst_seen)
        // ready rises with the reset write; give it the synchroniser's latency
        repeat (4) @(posedge clk);
        wb(1'b0, REG_STAT, 4'hf, 32'h0, st);
        `CHK("stuck ready", 1'b1, st[ST_RYBY_BIT])
        stuck <= 1'b0;
        // protected program and all-protected erase: status, then old contents
        prot <= 1'b1; len <= 8'h02;
        run_op(21'h00_0400, 16'h00c3, CTRL_TGL_BIT);
        `CHK("prot prog data", 16'h1234, st[31:16])
        erase <= 1'b1;
        run_op(21'h01_0000, 16'h0030, CTRL_TGL_BIT);
        `CHK("prot erase data", 16'h1234, st[31:16])
        `CHK("prot erase flags", 4'ha, st[3:0])
        // suspended erase: toggle bit one steady, poll bit high, ready released
        prot <= 1'b0; susp <= 1'b1;
        run_op(21'h01_0000, 16'h0030, CTRL_TGL_BIT);
        `CHK("susp poll bit", 1'b1, st[16 + POLL_POS])
        `CHK("susp flags", 4'ha, st[3:0])
        close_out();
    end
    // watchdog sized well above the full sequence
    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        close_out();
    end
endmodule
